/* rtl/remap_defs.svh */
// Register offsets, field positions and reset values of the remap command block
`ifndef REMAP_DEFS_SVH
`define REMAP_DEFS_SVH
// ****************
// Register offsets
// ****************
`define ADDR_W 12
`define CMD_REG_OFF 12'h018
`define STS_REG_OFF 12'h01c
`define RTBASE_REG_OFF 12'h020
`define CAP_REG_OFF 12'h024
// ****************
// Field positions
// ****************
`define TE_BIT 31
`define RPL_BIT 30
`define PTR_MSB 31
`define PTR_LSB 12
`define MODE_MSB 11
`define MODE_LSB 10
`define CAP_DRAIN_BIT 1
`define CAP_SCALABLE_BIT 0
// ****************
// Reset values and bus encodings
// ****************
`define RTBASE_RESET 32'h0000_0000
`define HSIZE_WORD 3'h2
`endif

/* rtl/remap_pkg.sv */
// Types shared by the remap command block
package remap_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BOUNDARY,
        ST_INVAL
    } te_state_e;

    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [31:0] data;
    } bus_wr_s;
endpackage

/* rtl/ahb_lite_slave.sv */
// AHB-Lite slave front end with zero wait states
`include "remap_defs.svh"
module ahb_lite_slave
    import remap_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register side
    output bus_wr_s wr,
    output logic [11:0] rdAddr,
    input wire logic [31:0] rdData
);
    logic addrPhase;
    logic wrPend;
    logic next_wrPend;
    logic [11:0] wrAddr;
    logic [11:0] next_wrAddr;
    logic [31:0] next_hrdata;

    always_comb begin
        addrPhase = hsel && htrans[1] && hready;
        rdAddr = haddr[11:0];
        next_wrPend = addrPhase && hwrite && (hsize == `HSIZE_WORD);
        next_wrAddr = addrPhase ? haddr[11:0] : wrAddr;
        next_hrdata = (addrPhase && !hwrite) ? rdData : hrdata;
        wr.en = wrPend;
        wr.addr = wrAddr;
        wr.data = hwdata;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPend <= 1'b0;
            wrAddr <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend <= next_wrPend;
            wrAddr <= next_wrAddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

/* rtl/txn_tracker.sv */
// Counter of in-flight DMA transactions giving a boundary indication
module txn_tracker #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Transaction events
    input wire logic txnStart,
    input wire logic txnEnd,
    // Boundary
    output logic idle
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (txnStart && !txnEnd) begin
            next_cnt = cnt + 1'b1;
        end else if (!txnStart && txnEnd && cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
        idle = (cnt == '0) && !txnStart;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule

/* rtl/remap_global_command_upper.sv */
// Translation-enable and root-pointer-load command logic of the remap unit
`include "remap_defs.svh"

module remap_global_command_upper
    import remap_pkg::*;
#(
    parameter bit SCALABLE_SUPPORT = 1'b1,
    parameter bit DRAIN_SUPPORT = 1'b1,
    parameter int TXN_CNT_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Remapping datapath
    input wire logic txnStart,
    input wire logic txnEnd,
    input wire logic drainDone,
    input wire logic invalDone,
    output logic remapActive,
    output logic [19:0] rootPtr,
    output logic [1:0] tableMode,
    output logic rootLoadPulse,
    output logic cacheInvalReq
);
    // ****************
    // Bus front end
    // ****************
    bus_wr_s wr;
    logic [11:0] rdAddr;
    logic [31:0] rdData;
    logic txnIdle;

    ahb_lite_slave u_bus (
        .mclk(mclk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr(wr),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    txn_tracker #(
        .CNT_W(TXN_CNT_W)
    ) u_txn (
        .mclk(mclk),
        .rst(rst),
        .txnStart(txnStart),
        .txnEnd(txnEnd),
        .idle(txnIdle)
    );

    // ****************
    // Command decode
    // ****************
    logic cmdWrite;
    logic teWrite;
    logic rplWrite;
    logic switchReady;
    te_state_e state;
    te_state_e next_state;
    logic teStatus;
    logic next_teStatus;
    logic targetEn;
    logic next_targetEn;
    logic next_remapActive;
    logic next_cacheInvalReq;

    always_comb begin
        // Bits 29:28 and below are not looked at
        cmdWrite = wr.en && (wr.addr == `CMD_REG_OFF);
        teWrite = cmdWrite && (wr.data[`TE_BIT] != teStatus) && (state == ST_IDLE);
        rplWrite = cmdWrite && wr.data[`RPL_BIT];
        switchReady = txnIdle && (!DRAIN_SUPPORT || drainDone);
    end

    // ****************
    // Enable sequencer
    // ****************
    always_comb begin
        next_state = state;
        next_teStatus = teStatus;
        next_targetEn = targetEn;
        next_remapActive = remapActive;
        next_cacheInvalReq = cacheInvalReq;
        case (state)
            ST_IDLE: begin
                if (teWrite) begin
                    next_targetEn = wr.data[`TE_BIT];
                    next_state = ST_BOUNDARY;
                end
            end
            ST_BOUNDARY: begin
                if (switchReady) begin
                    next_remapActive = targetEn;
                    if (!targetEn && SCALABLE_SUPPORT) begin
                        next_cacheInvalReq = 1'b1;
                        next_state = ST_INVAL;
                    end else begin
                        next_teStatus = targetEn;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_INVAL: begin
                if (invalDone) begin
                    next_cacheInvalReq = 1'b0;
                    next_teStatus = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            teStatus <= 1'b0;
            targetEn <= 1'b0;
            remapActive <= 1'b0;
            cacheInvalReq <= 1'b0;
        end else begin
            state <= next_state;
            teStatus <= next_teStatus;
            targetEn <= next_targetEn;
            remapActive <= next_remapActive;
            cacheInvalReq <= next_cacheInvalReq;
        end
    end

    // ****************
    // Root pointer load
    // ****************
    logic [31:0] rtBase;
    logic [31:0] next_rtBase;
    logic rtpStatus;
    logic next_rtpStatus;
    logic [19:0] next_rootPtr;
    logic [1:0] next_tableMode;
    logic next_rootLoadPulse;

    always_comb begin
        next_rtBase = rtBase;
        next_rtpStatus = rtpStatus;
        next_rootPtr = rootPtr;
        next_tableMode = tableMode;
        next_rootLoadPulse = rplWrite;
        if (wr.en && (wr.addr == `RTBASE_REG_OFF)) begin
            next_rtBase = wr.data;
        end
        if (rplWrite) begin
            next_rootPtr = rtBase[`PTR_MSB:`PTR_LSB];
            next_tableMode = rtBase[`MODE_MSB:`MODE_LSB];
            next_rtpStatus = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rtBase <= `RTBASE_RESET;
            rtpStatus <= 1'b0;
            rootPtr <= 20'h00000;
            tableMode <= 2'h0;
            rootLoadPulse <= 1'b0;
        end else begin
            rtBase <= next_rtBase;
            rtpStatus <= next_rtpStatus;
            rootPtr <= next_rootPtr;
            tableMode <= next_tableMode;
            rootLoadPulse <= next_rootLoadPulse;
        end
    end

    // ****************
    // Read mux
    // ****************
    always_comb begin
        rdData = 32'h0000_0000;
        case (rdAddr)
            `CMD_REG_OFF: begin
                rdData = 32'h0000_0000;
            end
            `STS_REG_OFF: begin
                rdData[`TE_BIT] = teStatus;
                rdData[`RPL_BIT] = rtpStatus;
            end
            `RTBASE_REG_OFF: begin
                rdData = rtBase;
            end
            `CAP_REG_OFF: begin
                rdData[`CAP_DRAIN_BIT] = DRAIN_SUPPORT;
                rdData[`CAP_SCALABLE_BIT] = SCALABLE_SUPPORT;
            end
            default: begin
                rdData = 32'h0000_0000;
            end
        endcase
    end

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_te_cmd;
        teWrite;
    endsequence

    sequence s_cmd_read;
        hsel && htrans[1] && hready && !hwrite && (haddr[11:0] == `CMD_REG_OFF);
    endsequence

    sequence s_inval_done;
        (state == ST_INVAL) && invalDone;
    endsequence

    sequence s_switch_taken;
        (state == ST_BOUNDARY) && switchReady;
    endsequence

    chk_te_request_taken: assert property (
        s_te_cmd |=> (state == ST_BOUNDARY) && (targetEn == $past(wr.data[`TE_BIT])))
        else $error("Translation command not taken");
    chk_te_status_disable: assert property (
        s_inval_done |=> !teStatus && !cacheInvalReq && (state == ST_IDLE))
        else $error("Disable status not reported");
    chk_switch_boundary: assert property (
        (remapActive != $past(remapActive)) |-> $past(txnIdle))
        else $error("Remapping switched inside a transaction");
    chk_drain_before_enable: assert property (
        $rose(teStatus) |-> (!DRAIN_SUPPORT || $past(drainDone)) && remapActive)
        else $error("Enable completed before drain");
    chk_inval_on_disable: assert property (
        $fell(teStatus) |-> (!SCALABLE_SUPPORT || $past(cacheInvalReq && invalDone)))
        else $error("Disable completed without invalidation");
    chk_cmd_read_zero: assert property (
        s_cmd_read |=> (hrdata == 32'h0000_0000))
        else $error("Command register read returned data");
    chk_root_load: assert property (
        rplWrite |=> rootLoadPulse && (rootPtr == $past(rtBase[`PTR_MSB:`PTR_LSB]))
            && (tableMode == $past(rtBase[`MODE_MSB:`MODE_LSB])))
        else $error("Root pointer not loaded");
    chk_root_status: assert property (
        rootLoadPulse |-> rtpStatus ##1 rtpStatus)
        else $error("Root pointer status not set");
    chk_zero_no_load: assert property (
        (cmdWrite && !wr.data[`RPL_BIT]) |=> !rootLoadPulse)
        else $error("Zero write started a root load");
    chk_load_pulse_cause: assert property (
        rootLoadPulse |-> $past(rplWrite))
        else $error("Root load pulse without a write");
    chk_enable_status: assert property (
        s_switch_taken ##0 targetEn |=> teStatus && remapActive && (state == ST_IDLE))
        else $error("Enable status not reported");
    chk_hold_in_txn: assert property (
        (state == ST_BOUNDARY) && !txnIdle |=> $stable(remapActive) && $stable(teStatus))
        else $error("Remapping switched with a transaction open");
    chk_hold_for_drain: assert property (
        (state == ST_BOUNDARY) && DRAIN_SUPPORT && !drainDone |=> $stable(teStatus) && (state == ST_BOUNDARY))
        else $error("Command completed before drain");
    chk_disable_inval_req: assert property (
        s_switch_taken ##0 !targetEn |=> (cacheInvalReq == SCALABLE_SUPPORT) && !remapActive)
        else $error("Disable did not request invalidation");
    chk_reserved_ignored: assert property (
        cmdWrite && (state == ST_IDLE) && (wr.data[`TE_BIT] == teStatus) && !wr.data[`RPL_BIT]
            |=> (state == ST_IDLE) && !rootLoadPulse && $stable(rootPtr))
        else $error("Reserved command bits acted on");
endmodule

/* tb/remap_global_command_upper_test.sv */
// Self-checking bench for the remap command block
`include "remap_defs.svh"
module remap_global_command_upper_test
    import remap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam bit DRAIN = 1'b1;
    localparam bit SCAL = 1'b1;
    logic mclk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, tableMode;
    logic [2:0] hsize;
    logic txnStart, txnEnd, drainDone, invalDone;
    logic remapActive, rootLoadPulse, cacheInvalReq;
    logic [19:0] rootPtr;
    logic [31:0] dummy;
    int miscompares = 0;
    int checks = 0;

    remap_global_command_upper #(.SCALABLE_SUPPORT(SCAL), .DRAIN_SUPPORT(DRAIN), .TXN_CNT_W(8)) dut_u (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .txnStart(txnStart), .txnEnd(txnEnd), .drainDone(drainDone),
        .invalDone(invalDone), .remapActive(remapActive), .rootPtr(rootPtr), .tableMode(tableMode),
        .rootLoadPulse(rootLoadPulse), .cacheInvalReq(cacheInvalReq)
    );

    // ****************
    // Tasks
    // ****************
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single transfer; hreadyout is awaited at both phases
    task automatic busCycle(input logic [11:0] addr, input logic wr, input logic [31:0] data,
                            input logic [2:0] size, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, addr};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= size;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'b00;
        hwdata <= data;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
        checkWord({31'h0, hresp}, 32'h0);
    endtask

    task automatic wrReg(input logic [11:0] addr, input logic [31:0] data);
        logic [31:0] d;
        busCycle(addr, 1'b1, data, `HSIZE_WORD, d);
    endtask

    task automatic rdChk(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        busCycle(addr, 1'b0, 32'h0, `HSIZE_WORD, d);
        checkWord(d, exp);
    endtask

    task automatic waitRemap(input logic exp);
        int n;
        n = 0;
        while (remapActive !== exp && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        checkWord({31'h0, remapActive}, {31'h0, exp});
    endtask

    task automatic pulseTxn(input logic isEnd);
        @(posedge mclk);
        if (isEnd) txnEnd <= 1'b1;
        else txnStart <= 1'b1;
        @(posedge mclk);
        txnStart <= 1'b0;
        txnEnd <= 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************
    // Clock and watchdog
    // ****************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        #(50 * 4000);
        miscompares++;
        complete_run();
    end

    // ****************
    // Tests
    // ****************
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} <= '0;
        {txnStart, txnEnd, invalDone} <= '0;
        drainDone <= 1'b1;
        repeat (6) @(posedge mclk);
        checkWord({25'h0, hreadyout, hresp, remapActive, rootLoadPulse, cacheInvalReq, tableMode}, 32'h40);
        rst <= 1'b0;
        rdChk(`STS_REG_OFF, 32'h0);
        rdChk(`RTBASE_REG_OFF, `RTBASE_RESET);
        rdChk(`CAP_REG_OFF, {30'h0, DRAIN, SCAL});
        $display("test reset done");

        wrReg(`RTBASE_REG_OFF, 32'habcd_ec00);
        wrReg(`CMD_REG_OFF, 32'h3000_0000);
        #1;
        checkWord({31'h0, rootLoadPulse}, 32'h0);
        checkWord({12'h0, rootPtr}, 32'h0);
        rdChk(`STS_REG_OFF, 32'h0);
        wrReg(`CMD_REG_OFF, 32'h4000_0000);
        #1;
        checkWord({31'h0, rootLoadPulse}, 32'h1);
        checkWord({12'h0, rootPtr}, 32'h000a_bcde);
        checkWord({30'h0, tableMode}, 32'h3);
        @(posedge mclk);
        #1;
        checkWord({31'h0, rootLoadPulse}, 32'h0);
        rdChk(`STS_REG_OFF, 32'h4000_0000);
        rdChk(`CMD_REG_OFF, 32'h0);
        busCycle(`RTBASE_REG_OFF, 1'b1, 32'h1234_5000, 3'h1, dummy);
        rdChk(`RTBASE_REG_OFF, 32'habcd_ec00);
        rdChk(12'h100, 32'h0);
        $display("test root load done");

        // Enable held off by an open transaction, then by draining
        pulseTxn(1'b0);
        wrReg(`CMD_REG_OFF, 32'h8000_0000);
        repeat (5) @(posedge mclk);
        #1;
        checkWord({31'h0, remapActive}, 32'h0);
        drainDone <= 1'b0;
        pulseTxn(1'b1);
        repeat (5) @(posedge mclk);
        #1;
        checkWord({31'h0, remapActive}, 32'h0);
        rdChk(`STS_REG_OFF, 32'h4000_0000);
        drainDone <= 1'b1;
        waitRemap(1'b1);
        rdChk(`STS_REG_OFF, 32'hc000_0000);
        $display("test enable done");

        // Disable waits on cache invalidation
        wrReg(`CMD_REG_OFF, 32'h0000_0000);
        waitRemap(1'b0);
        checkWord({31'h0, cacheInvalReq}, 32'h1);
        rdChk(`STS_REG_OFF, 32'hc000_0000);
        invalDone <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        checkWord({31'h0, cacheInvalReq}, 32'h0);
        invalDone <= 1'b0;
        rdChk(`STS_REG_OFF, 32'h4000_0000);
        $display("test disable done");
        complete_run();
    end
endmodule
